// ==== ibs_status_flags.sv ====
// Status flag logic of the I2C bus interface with APB register access
`timescale 1ns/1ps
`default_nettype none
module ibs_status_flags
   import ibs_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // I2C pins, open drain
   input  wire logic              sclIn,
   output logic                   sclOut,
   output logic                   sclOe,
   input  wire logic              sdaIn,
   output logic                   sdaOut,
   output logic                   sdaOe,
   // Transfer engine, same clock
   input  wire logic              arbLostEvt,
   input  wire logic              transmitState,
   input  wire logic              ackDetect,
   // Interrupt
   output logic                   busInterruptRequest
);

   // Register hit test, shared by read and write decode
   function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] r);
      regHit = (a == r);
   endfunction

   // Pin sampling
   logic [1:0]   pinSync;
   logic [1:0]   pinPrev_q;
   logic [1:0]   pinPrev_d;
   ibs_bus_evt_t evt;
   logic         sclS;
   logic         sdaS;

   ibs_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk  (core_clk),
      .rst  (rst),
      .din  ({sclIn, sdaIn}),
      .dout (pinSync)
   );

   // Edge finding on the synchronised pins only
   always_comb begin
      sclS          = pinSync[1];
      sdaS          = pinSync[0];
      pinPrev_d     = pinSync;
      evt.startDet  = sclS & pinPrev_q[1] & pinPrev_q[0] & ~sdaS;
      evt.stopDet   = sclS & pinPrev_q[1] & ~pinPrev_q[0] & sdaS;
      evt.sclRise   = sclS & ~pinPrev_q[1];
   end

   // Registers
   logic                  ifEn_q,  ifEn_d;
   logic                  stt_q,   stt_d;
   logic                  wup_q,   wup_d;
   logic                  spie_q,  spie_d;
   logic [7:0]            sva_q,   sva_d;
   logic [IRQ_W-1:0]      irqEn_q, irqEn_d;
   logic [IRQ_W-1:0]      irqSt_q, irqSt_d;
   logic [31:0]           prdata_q, prdata_d;
   ibs_status_t           flags_q, flags_d;
   logic [7:0]            view_q,  view_d;
   logic                  frozen_q, frozen_d;
   logic [6:0]            shift_q, shift_d;
   logic [3:0]            bitCnt_q, bitCnt_d;
   logic                  firstByte_q, firstByte_d;
   logic                  busFree_q, busFree_d;
   ibs_pin_state_t        pin_q,   pin_d;
   logic [HOLD_W-1:0]     hold_q,  hold_d;

   // APB decode
   logic                  wrEn;
   logic                  rdSetup;
   logic                  rdStatus;
   logic                  wrCtrl;
   logic                  mapped;
   logic                  lrelReq;
   logic                  ifEnFall;
   logic                  wupFall;
   logic                  startGen;
   logic                  arbLost;
   logic                  eighth;
   logic [7:0]            rxByte;
   logic                  excSet;
   logic                  coiSet;
   logic [7:0]            liveStatus;

   // Zero-wait slave; one access phase cycle per transfer
   always_comb begin
      wrEn     = psel & penable & pwrite;
      rdSetup  = psel & ~penable & ~pwrite;
      rdStatus = psel & penable & ~pwrite & regHit(paddr, STATUS_ADDR);
      wrCtrl   = wrEn & regHit(paddr, CTRL_ADDR);
      mapped   = 1'b0;
      if (regHit(paddr, STATUS_ADDR)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, CTRL_ADDR)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, SVA_ADDR)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, IRQ_STAT_ADDR)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, IRQ_EN_ADDR)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, IRQ_CLR_ADDR)) begin
         mapped = 1'b1;
      end
      lrelReq  = wrCtrl & pwdata[CTRL_LREL];
      ifEnFall = wrCtrl & ifEn_q & ~pwdata[CTRL_IFEN];
      wupFall  = wrCtrl & wup_q & ~pwdata[CTRL_WUP];
      arbLost  = ifEn_q & arbLostEvt;
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Control registers; exit request is a write pulse, never stored
   always_comb begin
      ifEn_d  = ifEn_q;
      stt_d   = stt_q;
      wup_d   = wup_q;
      spie_d  = spie_q;
      sva_d   = sva_q;
      irqEn_d = irqEn_q;
      if (wrCtrl) begin
         ifEn_d = pwdata[CTRL_IFEN];
         wup_d  = pwdata[CTRL_WUP];
         spie_d = pwdata[CTRL_SPIE];
         if (pwdata[CTRL_STT]) begin
            stt_d = 1'b1;
         end
      end
      if (wrEn & regHit(paddr, SVA_ADDR)) begin
         sva_d = pwdata[7:0];
      end
      if (wrEn & regHit(paddr, IRQ_EN_ADDR)) begin
         irqEn_d = pwdata[IRQ_W-1:0];
      end
      // Trigger is consumed by the start, dropped by loss, exit or disable
      if (startGen | arbLost | lrelReq | ~ifEn_d) begin
         stt_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ifEn_q  <= 1'b0;
         stt_q   <= 1'b0;
         wup_q   <= 1'b0;
         spie_q  <= 1'b0;
         sva_q   <= SVA_RST;
         irqEn_q <= IRQ_RST;
      end else begin
         ifEn_q  <= ifEn_d;
         stt_q   <= stt_d;
         wup_q   <= wup_d;
         spie_q  <= spie_d;
         sva_q   <= sva_d;
         irqEn_q <= irqEn_d;
      end
   end

   // Start generation: SDA low for the hold time, then stretch SCL
   always_comb begin
      pin_d    = pin_q;
      hold_d   = hold_q;
      startGen = 1'b0;
      case (pin_q)
         PIN_IDLE: begin
            hold_d = '0;
            if (stt_q & ifEn_q & busFree_q & ~lrelReq) begin
               pin_d = PIN_HOLD;
            end
         end
         PIN_HOLD: begin
            hold_d = hold_q + HOLD_W'(1);
            if (hold_q == HOLD_W'(START_HOLD_CYC - 1)) begin
               startGen = 1'b1;
               pin_d    = PIN_STRETCH;
            end
         end
         PIN_STRETCH: begin
            hold_d = '0;
         end
         default: begin
            pin_d  = PIN_IDLE;
            hold_d = '0;
         end
      endcase
      // Loss, exit or disable releases both lines at once
      if (arbLost | lrelReq | ~ifEn_d | evt.stopDet) begin
         pin_d = PIN_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_q  <= PIN_IDLE;
         hold_q <= '0;
      end else begin
         pin_q  <= pin_d;
         hold_q <= hold_d;
      end
   end

   // Open drain: only ever pull low
   assign sdaOut = 1'b0;
   assign sclOut = 1'b0;
   assign sdaOe  = (pin_q != PIN_IDLE);
   assign sclOe  = (pin_q == PIN_STRETCH);

   // Address byte receiver, counts rising SCL edges after a start
   always_comb begin
      shift_d     = shift_q;
      bitCnt_d    = bitCnt_q;
      firstByte_d = firstByte_q;
      busFree_d   = busFree_q;
      rxByte      = {shift_q, sdaS};
      eighth      = ifEn_q & firstByte_q & evt.sclRise
                    & (bitCnt_q == EIGHTH_BIT);
      excSet      = eighth & ((rxByte[7:4] == EXT_NIBBLE_LO)
                    | (rxByte[7:4] == EXT_NIBBLE_HI));
      coiSet      = eighth & (rxByte[7:1] == sva_q[7:1]);
      if (evt.sclRise & firstByte_q) begin
         shift_d  = rxByte[6:0];
         bitCnt_d = bitCnt_q + 4'h1;
         if (eighth) begin
            firstByte_d = 1'b0;
         end
      end
      if (evt.startDet) begin
         bitCnt_d    = '0;
         firstByte_d = 1'b1;
         busFree_d   = 1'b0;
      end
      if (evt.stopDet) begin
         firstByte_d = 1'b0;
         busFree_d   = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         shift_q     <= '0;
         bitCnt_q    <= '0;
         firstByte_q <= 1'b0;
         busFree_q   <= 1'b1;
         pinPrev_q   <= '1;          // Idle high, so no false edge
      end else begin
         shift_q     <= shift_d;
         bitCnt_q    <= bitCnt_d;
         firstByte_q <= firstByte_d;
         busFree_q   <= busFree_d;
         pinPrev_q   <= pinPrev_d;
      end
   end

   // Flags: clears first, sets last so an event is never lost, save a start or stop in a disable cycle
   always_comb begin
      flags_d           = flags_q;
      flags_d.transmit  = transmitState;
      flags_d.ackDetect = ackDetect;
      if (ifEn_q & evt.startDet) begin
         flags_d.extCode   = 1'b0;
         flags_d.addrMatch = 1'b0;
         flags_d.startDet  = 1'b1;
         flags_d.stopDet   = 1'b0;
      end
      if (ifEn_q & evt.stopDet) begin
         flags_d.master    = 1'b0;
         flags_d.extCode   = 1'b0;
         flags_d.addrMatch = 1'b0;
         flags_d.startDet  = 1'b0;
         flags_d.stopDet   = 1'b1;
      end
      if (lrelReq) begin
         flags_d.master    = 1'b0;
         flags_d.extCode   = 1'b0;
         flags_d.addrMatch = 1'b0;
      end
      if (rdStatus) begin
         flags_d.arbLost = 1'b0;
      end
      if (ifEnFall) begin
         flags_d = STATUS_RST;
         flags_d.transmit  = transmitState;
         flags_d.ackDetect = ackDetect;
      end
      if (startGen) begin
         flags_d.master = 1'b1;
      end
      if (excSet) begin
         flags_d.extCode = 1'b1;
      end
      if (coiSet) begin
         flags_d.addrMatch = 1'b1;
      end
      if (arbLost) begin
         flags_d.arbLost = 1'b1;
         flags_d.master  = 1'b0;
      end
   end

   // Wakeup off freezes the visible status until the next start or stop
   always_comb begin
      liveStatus = flags_q;
      view_d     = view_q;
      frozen_d   = frozen_q;
      if (wupFall & ~frozen_q) begin
         frozen_d = 1'b1;
         view_d   = liveStatus;
      end
      if (evt.startDet | evt.stopDet) begin
         frozen_d = 1'b0;
      end
   end

   // Status register has no write path at all
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_q  <= STATUS_RST;
         view_q   <= STATUS_RST;
         frozen_q <= 1'b0;
      end else begin
         flags_q  <= flags_d;
         view_q   <= view_d;
         frozen_q <= frozen_d;
      end
   end

   // Interrupt status: sticky, write-one clear, new event wins
   always_comb begin
      irqSt_d = irqSt_q;
      if (wrEn & regHit(paddr, IRQ_CLR_ADDR)) begin
         irqSt_d = irqSt_q & ~pwdata[IRQ_W-1:0];
      end
      irqSt_d[IRQ_START] = irqSt_d[IRQ_START] | (ifEn_q & evt.startDet);
      irqSt_d[IRQ_STOP]  = irqSt_d[IRQ_STOP]
                           | (ifEn_q & spie_q & evt.stopDet);
      irqSt_d[IRQ_ALD]   = irqSt_d[IRQ_ALD] | arbLost;
      irqSt_d[IRQ_EXC]   = irqSt_d[IRQ_EXC] | excSet;
      irqSt_d[IRQ_COI]   = irqSt_d[IRQ_COI] | coiSet;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irqSt_q <= IRQ_RST;
      end else begin
         irqSt_q <= irqSt_d;
      end
   end

   assign busInterruptRequest = |(irqSt_q & irqEn_q);

   // Read data captured in the setup phase, stable through access
   always_comb begin
      prdata_d = prdata_q;
      if (rdSetup) begin
         prdata_d = '0;
         if (regHit(paddr, STATUS_ADDR)) begin
            prdata_d[7:0] = frozen_q ? view_q : liveStatus;
         end else if (regHit(paddr, CTRL_ADDR)) begin
            prdata_d[CTRL_IFEN] = ifEn_q;
            prdata_d[CTRL_WUP]  = wup_q;
            prdata_d[CTRL_SPIE] = spie_q;
         end else if (regHit(paddr, SVA_ADDR)) begin
            prdata_d[7:0] = sva_q;
         end else if (regHit(paddr, IRQ_STAT_ADDR)) begin
            prdata_d[IRQ_W-1:0] = irqSt_q;
         end else if (regHit(paddr, IRQ_EN_ADDR)) begin
            prdata_d[IRQ_W-1:0] = irqEn_q;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_q <= '0;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;

endmodule
`default_nettype wire

// ==== ibs_pkg.sv ====
// Constants, register map and carrier types of the bus status flag block
package ibs_pkg;

   // APB address width and register byte addresses
   localparam int          ADDR_W        = 24;
   localparam logic [23:0] STATUS_INDEX  = 24'hFFF51;
   localparam logic [23:0] STATUS_ADDR   = STATUS_INDEX << 2;
   localparam logic [23:0] CTRL_ADDR     = 24'h3FFD48;
   localparam logic [23:0] SVA_ADDR      = 24'h3FFD4C;
   localparam logic [23:0] IRQ_STAT_ADDR = 24'h3FFD50;
   localparam logic [23:0] IRQ_EN_ADDR   = 24'h3FFD54;
   localparam logic [23:0] IRQ_CLR_ADDR  = 24'h3FFD58;

   // Control register fields
   localparam int CTRL_IFEN = 0;
   localparam int CTRL_STT  = 1;
   localparam int CTRL_LREL = 2;
   localparam int CTRL_WUP  = 3;
   localparam int CTRL_SPIE = 4;

   // Interrupt status, enable and clear fields
   localparam int IRQ_W     = 5;
   localparam int IRQ_START = 0;
   localparam int IRQ_STOP  = 1;
   localparam int IRQ_ALD   = 2;
   localparam int IRQ_EXC   = 3;
   localparam int IRQ_COI   = 4;

   // Reset values
   localparam logic [7:0]       STATUS_RST  = 8'h00;
   localparam logic [7:0]       SVA_RST     = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST     = 5'h00;

   // Address byte decode
   localparam logic [3:0] EXT_NIBBLE_LO = 4'h0;
   localparam logic [3:0] EXT_NIBBLE_HI = 4'hF;
   localparam logic [3:0] EIGHTH_BIT    = 4'h7;

   // Timing: start hold time while driving SDA low with SCL high
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int START_HOLD_NS  = 600;
   localparam int START_HOLD_CYC =
      (START_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_W         = 8;

   // Status register layout, bit 7 first
   typedef struct packed {
      logic master;
      logic arbLost;
      logic extCode;
      logic addrMatch;
      logic transmit;
      logic ackDetect;
      logic startDet;
      logic stopDet;
   } ibs_status_t;

   // Bus conditions seen on the sampled pins
   typedef struct packed {
      logic startDet;
      logic stopDet;
      logic sclRise;
   } ibs_bus_evt_t;

   // Pin driver for start generation
   typedef enum logic [1:0] {
      PIN_IDLE    = 2'b00,
      PIN_HOLD    = 2'b01,
      PIN_STRETCH = 2'b10
   } ibs_pin_state_t;

endpackage

// ==== ibs_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module ibs_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // Next values; idle bus level is high
   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;

endmodule
`default_nettype wire

// ==== ibs_status_flags_chk.sv ====
// Concurrent checks on the ports of the bus status flag block
`timescale 1ns/1ps
`default_nettype none
module ibs_status_flags_chk
   import ibs_pkg::*;
(
   // Clock, reset and APB
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [31:0]       prdata,
   input  wire logic              pslverr,
   // Pins, events and interrupt
   input  wire logic              sclOe,
   input  wire logic              sdaOe,
   input  wire logic              arbLostEvt,
   input  wire logic              busInterruptRequest
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // Decoded APB phases
   logic acc;
   logic stRd;
   logic stSet;
   logic ctlWr;
   assign acc   = psel && penable;
   assign stRd  = acc && !pwrite && paddr == STATUS_ADDR;
   assign stSet = psel && !penable && !pwrite && paddr == STATUS_ADDR;
   assign ctlWr = acc && pwrite && paddr == CTRL_ADDR;

   chk_reset_quiet: assert property (
      $fell(rst) |-> !sclOe && !sdaOe && !busInterruptRequest
         && prdata == 32'h0)
      else $error("outputs active right after reset");
   chk_status_width: assert property (
      stRd |-> prdata[31:8] == 24'h0)
      else $error("status read has bits above the byte");
   chk_arb_release: assert property (
      arbLostEvt |=> !sclOe && !sdaOe)
      else $error("lines still driven after arbitration loss");
   chk_exit_release: assert property (
      ctlWr && pwdata[CTRL_LREL] |=> !sclOe && !sdaOe)
      else $error("lines still driven after exit request");
   chk_off_release: assert property (
      ctlWr && !pwdata[CTRL_IFEN] |=> !sclOe && !sdaOe)
      else $error("lines still driven after disable");
   chk_start_order: assert property (
      $rose(sclOe) |-> sdaOe && $past(sdaOe, 8))
      else $error("clock pulled before data held low");
   chk_loss_readclr: assert property (
      stRd && !arbLostEvt ##1 !psel && !arbLostEvt ##1 stSet
         |=> !prdata[6])
      else $error("loss flag survived a status read");
   chk_status_noerr: assert property (
      acc && paddr == STATUS_ADDR |-> !pslverr)
      else $error("status access answered with error");
endmodule

bind ibs_status_flags ibs_status_flags_chk i_chk (
   .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pslverr, .sclOe, .sdaOe, .arbLostEvt, .busInterruptRequest);
`default_nettype wire

// ==== ibs_bus_model.sv ====
// Far-side bus party that frames address bytes on the link
`timescale 1ns/1ps
`default_nettype none
module ibs_bus_model (
   // Open-drain pulls, high drives the line low
   output var logic sclPull,
   output var logic sdaPull
);
   // Half of the 48 ns link period; clock held low between frames
   localparam int HALF = 24;

   initial begin
      sclPull = 1'b0;
      sdaPull = 1'b0;
   end

   // Start or repeated start, then address MSB first and a ninth clock
   task automatic frame(input logic [7:0] addr);
      sdaPull = 1'b0;
      #(HALF/2);
      sclPull = 1'b0;
      #(HALF/2);
      sdaPull = 1'b1;
      #HALF;
      for (int i = 8; i >= 0; i--) begin
         sclPull = 1'b1;
         #(HALF/2);
         // Data moves only while the clock is low
         sdaPull = (i > 0) ? !addr[i-1] : 1'b0;
         #(HALF/2);
         sclPull = 1'b0;
         #HALF;
      end
      // Clock left held low, as in a stretch
      sclPull = 1'b1;
   endtask

   // Stop: data rises while the clock is high
   task automatic stop();
      sdaPull = 1'b1;
      #(HALF/2);
      sclPull = 1'b0;
      #(HALF/2);
      sdaPull = 1'b0;
      #HALF;
   endtask
endmodule
`default_nettype wire

// ==== ibs_tb.sv ====
// Self-checking testbench of the bus status flag block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ibs_pkg::*;
;
   // Bench signals
   logic              core_clk = 1'b0;
   logic              rst = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 24'h0;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic              pready, pslverr, sclOut, sclOe, sdaOut, sdaOe;
   logic              arbLostEvt = 1'b0;
   logic              transmitState = 1'b0;
   logic              ackDetect = 1'b0;
   logic              busInterruptRequest, sclPull, sdaPull;
   int                badCount = 0;
   int                checked = 0;
   // Wired-AND of both parties, pull-ups idle high
   wire logic         sclLine = !(sclOe || sclPull);
   wire logic         sdaLine = !(sdaOe || sdaPull);

   always #2.5 core_clk = !core_clk;

   ibs_status_flags i_dut (
      .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sclIn(sclLine), .sclOut, .sclOe,
      .sdaIn(sdaLine), .sdaOut, .sdaOe, .arbLostEvt, .transmitState,
      .ackDetect, .busInterruptRequest);
   ibs_bus_model i_bus (.sclPull, .sdaPull);

   // Closing verdict, shared by the sequence and the watchdog
   task automatic printVerdict();
      if (badCount == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; idle edge after it so strobes never re-assert
   task automatic apb(input logic [23:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(a, 1'b1, d, q, e);
   endtask

   // Word read compared under a mask
   task automatic rd(input logic [23:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(a, 1'b0, 32'h0, q, e);
      cmp(q & m, exp);
   endtask

   task automatic lose();
      arbLostEvt <= 1'b1;
      @(posedge core_clk);
      arbLostEvt <= 1'b0;
      @(posedge core_clk);
   endtask

   // Trigger a start and wait, bounded, for the clock pull
   task automatic startGen();
      int n;
      n = 0;
      wr(CTRL_ADDR, 32'h3);
      while (sclOe !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      cmp(sclOe, 1'b1);
      cmp({sdaOe, sclOut, sdaOut}, 3'b100);
   endtask

   // Address frames and the status each leaves behind
   logic [7:0] addrs [5] = '{8'h0E, 8'hF2, 8'hA5, 8'h5A, 8'hA4};
   logic [7:0] exps  [5] = '{8'h22, 8'h22, 8'h12, 8'h02, 8'h12};

   // Main sequence; status reads after a frame happen while the clock is stretched
   initial begin
      logic [31:0] q;
      logic e;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(STATUS_ADDR, 32'hFF, 32'h0);
      apb(24'h000100, 1'b0, 32'h0, q, e);
      cmp({q[30:0], e}, 32'h1);
      transmitState <= 1'b1;
      ackDetect <= 1'b1;
      @(posedge core_clk);
      rd(STATUS_ADDR, 32'hFF, 32'h0C);
      transmitState <= 1'b0;
      ackDetect <= 1'b0;
      wr(CTRL_ADDR, 32'h1);
      wr(SVA_ADDR, 32'hA4);
      wr(IRQ_EN_ADDR, 32'h1F);
      foreach (addrs[i]) begin
         i_bus.frame(addrs[i]);
         @(posedge core_clk);
         rd(STATUS_ADDR, 32'hFF, exps[i]);
      end
      i_bus.stop();
      @(posedge core_clk);
      rd(STATUS_ADDR, 32'hFF, 32'h01);
      // Interrupt raised, masked and cleared
      cmp(busInterruptRequest, 1'b1);
      rd(IRQ_STAT_ADDR, 32'hFF, 32'h19);
      wr(IRQ_EN_ADDR, 32'h0);
      cmp(busInterruptRequest, 1'b0);
      wr(IRQ_EN_ADDR, 32'h1F);
      wr(IRQ_CLR_ADDR, 32'h1F);
      cmp(busInterruptRequest, 1'b0);
      // Exit request drops the extension flag
      i_bus.frame(8'h0E);
      @(posedge core_clk);
      wr(CTRL_ADDR, 32'h5);
      rd(STATUS_ADDR, 32'hF0, 32'h0);
      i_bus.stop();
      @(posedge core_clk);
      // Loss flag: set, read-clear, write ignored, disable clears
      lose();
      rd(STATUS_ADDR, 32'hC0, 32'h40);
      rd(STATUS_ADDR, 32'hC0, 32'h0);
      lose();
      wr(STATUS_ADDR, 32'hFF);
      rd(STATUS_ADDR, 32'hFF, 32'h41);
      lose();
      wr(CTRL_ADDR, 32'h0);
      rd(STATUS_ADDR, 32'hC0, 32'h0);
      wr(CTRL_ADDR, 32'h1);
      // Master flag: start, exit, then start and loss
      startGen();
      rd(STATUS_ADDR, 32'hC0, 32'h80);
      wr(CTRL_ADDR, 32'h5);
      rd(STATUS_ADDR, 32'h80, 32'h0);
      i_bus.stop();
      @(posedge core_clk);
      startGen();
      lose();
      rd(STATUS_ADDR, 32'hC0, 32'h40);
      i_bus.stop();
      @(posedge core_clk);
      // Wakeup with stop interrupt on; status read while frozen, then after a start
      wr(CTRL_ADDR, 32'h19);
      wr(CTRL_ADDR, 32'h11);
      transmitState <= 1'b1;
      @(posedge core_clk);
      rd(STATUS_ADDR, 32'hFF, 32'h01);
      i_bus.frame(8'h5A);
      @(posedge core_clk);
      rd(STATUS_ADDR, 32'hFF, 32'h0A);
      transmitState <= 1'b0;
      printVerdict();
   end

   // Watchdog far beyond the expected run of some 6 us
   initial begin
      #200000;
      badCount++;
      printVerdict();
   end
endmodule
`default_nettype wire
